// ===== hdl/copro_regs.svh
// port offsets, field positions, reset values and timing counts
`ifndef COPRO_REGS_SVH
`define COPRO_REGS_SVH

// i/o port offsets
`define BUSY_CLR_OFS 16'h00F0
`define MODE_RST_OFS 16'h00F1
`define PORT_A_OFS   16'h00F8
`define PORT_B_OFS   16'h00FA
`define PORT_C_OFS   16'h00FC

// data that a busy-clearing write must carry
`define CLR_DATA     8'h00

// opcode word fields
`define OPC_LSB      0
`define OPC_MSB      3
`define FMT_LSB      4
`define FMT_MSB      6
`define IDX_LSB      8
`define IDX_MSB      10

// exception flag positions
`define EXC_INV      0
`define EXC_DEN      1
`define EXC_ZDIV     2
`define EXC_OVF      3
`define EXC_UNF      4
`define EXC_PREC     5

// reset values and timing
`define MASK_RST     6'h3F
`define EXEC_CYCLES  8'h08
`define RES_WORDS    3'h5

`endif

// ===== hdl/copro_pkg.sv
// types shared by the coprocessor port glue
package copro_pkg;

   // opcode held in the low nibble of a port a write
   typedef enum logic [3:0] {
      OP_NOP   = 4'h0,
      OP_LOAD  = 4'h1,
      OP_POP   = 4'h2,
      OP_ADD   = 4'h3,
      OP_SUB   = 4'h4,
      OP_DIV   = 4'h5,
      OP_STORE = 4'h6,
      OP_ENTER_PROTECTED_MODE_INSTR = 4'h7,
      OP_LDREG = 4'h8,
      OP_CLEX  = 4'h9
   } op_e;

   // numeric formats, three classes
   typedef enum logic [2:0] {
      FMT_I16 = 3'h0,
      FMT_I32 = 3'h1,
      FMT_I64 = 3'h2,
      FMT_BCD = 3'h3,
      FMT_R32 = 3'h4,
      FMT_R64 = 3'h5,
      FMT_R80 = 3'h6,
      FMT_BAD = 3'h7
   } fmt_e;

   // stack commands
   typedef enum logic [1:0] {
      STK_HOLD  = 2'h0,
      STK_PUSH  = 2'h1,
      STK_POP   = 2'h2,
      STK_POPWR = 2'h3
   } stk_e;

   // execution sequencer, gray along idle-run-idle
   typedef enum logic {
      EX_IDLE = 1'b0,
      EX_RUN  = 1'b1
   } exec_e;

   // one host i/o cycle
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wrData;
      logic        wr;
      logic        rd;
      logic        byteXfer;
   } io_req_s;

   // outcome of one executed instruction
   typedef struct packed {
      logic [5:0]  exc;
      stk_e        stk;
      logic [79:0] data;
      logic        wrRes;
      logic        enter_protected_mode_instr;
      logic        clex;
   } eval_s;

   // register stack state
   typedef struct packed {
      logic [7:0][79:0] regs;
      logic [3:0]       depth;
   } stack_s;

   // glue and sequencer state
   typedef struct packed {
      logic [15:0] rdData;
      logic        hostBusy;
      logic        busyLatch;
      logic        irq;
      logic        errPrev;
      logic        protMode;
      logic [5:0]  flags;
      logic [5:0]  mask;
      logic [79:0] operand;
      logic [79:0] result;
      logic [2:0]  resIdx;
      logic [15:0] opWord;
      logic [7:0]  cnt;
      exec_e       exec;
   } glue_s;

endpackage : copro_pkg

// ===== hdl/stack_file.sv
// eight 80-bit registers used as a stack or as a fixed set
`timescale 1ns/100ps
`include "copro_regs.svh"
module stack_file
   import copro_pkg::*;
(
   // clock and reset
   input  wire logic   mclk,
   input  wire logic   rst_b,
   input  wire logic   clkEn,
   // commands
   input  wire logic   clear,
   input  wire stk_e   cmd,
   input  wire logic [79:0] wrData,
   input  wire logic [2:0]  fixIdx,
   // views
   output logic [79:0] st0,
   output logic [79:0] st1,
   output logic [79:0] fixVal,
   output logic [3:0]  depth
);

   stack_s r;
   stack_s n;

   // push, pop, and pop with rewrite of the new top
   always_comb begin
      n = r;
      case (cmd)
         STK_PUSH: begin
            n.regs[r.depth[2:0]] = wrData;
            n.depth = r.depth + 4'h1;
         end
         STK_POP: begin
            n.depth = r.depth - 4'h1;
         end
         STK_POPWR: begin
            n.regs[3'(r.depth - 4'h2)] = wrData;
            n.depth = r.depth - 4'h1;
         end
         default: begin
            n.depth = r.depth;
         end
      endcase
      if (clear) begin
         n.depth = 4'h0;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
      end else if (clkEn) begin
         r <= n;
      end
   end

   // top two entries and an indexed register
   assign st0    = r.regs[3'(r.depth - 4'h1)];
   assign st1    = r.regs[3'(r.depth - 4'h2)];
   assign fixVal = r.regs[fixIdx];
   assign depth  = r.depth;

endmodule : stack_file

// ===== hdl/op_eval.sv
// executes one instruction on the stack view and flags exceptions
`timescale 1ns/100ps
`include "copro_regs.svh"
module op_eval
   import copro_pkg::*;
(
   // instruction and operands
   input  wire logic [15:0] opWord,
   input  wire logic [79:0] operand,
   input  wire logic [79:0] st0,
   input  wire logic [79:0] st1,
   input  wire logic [79:0] fixVal,
   input  wire logic [3:0]  depth,
   // outcome
   output eval_s            res
);

   // high when a value does not fit a signed field of w bits
   function automatic logic lostBits(input logic [79:0] v,
                                     input logic [6:0] w);
      logic [79:0] hi;
      hi = v >> (w - 7'h01);
      lostBits = !(hi == 80'h0 || hi == ({80{1'b1}} >> (w - 7'h01)));
   endfunction : lostBits

   op_e         op;
   fmt_e        fmt;
   logic [79:0] sum;
   logic [79:0] dif;

   always_comb begin
      op  = op_e'(opWord[`OPC_MSB:`OPC_LSB]);
      fmt = fmt_e'(opWord[`FMT_MSB:`FMT_LSB]);
      sum = st1 + st0;
      dif = st1 - st0;
      res = '0;
      case (op)
         OP_NOP: begin
            res.stk = STK_HOLD;
         end
         OP_LOAD: begin
            if (depth == 4'h8) begin
               res.exc[`EXC_INV] = 1'b1;
            end else begin
               res.stk  = STK_PUSH;
               res.data = operand;
            end
            if (fmt >= FMT_R32 && fmt != FMT_BAD &&
                operand[78:64] == 15'h0000 && operand[63:0] != 64'h0)
            begin
               res.exc[`EXC_DEN] = 1'b1;
            end
         end
         OP_LDREG: begin
            if (depth == 4'h8) begin
               res.exc[`EXC_INV] = 1'b1;
            end else begin
               res.stk  = STK_PUSH;
               res.data = fixVal;
            end
         end
         OP_POP: begin
            if (depth == 4'h0) begin
               res.exc[`EXC_INV] = 1'b1;
            end else begin
               res.stk = STK_POP;
            end
         end
         OP_ADD, OP_SUB: begin
            res.data  = (op == OP_ADD) ? sum : dif;
            res.wrRes = 1'b1;
            if (depth < 4'h2) begin
               res.exc[`EXC_INV] = 1'b1;
            end else begin
               res.stk = STK_POPWR;
            end
            if ((op == OP_ADD && st1[79] == st0[79] && sum[79] != st1[79])
               || (op == OP_SUB && st1[79] != st0[79]
                   && dif[79] != st1[79])) begin
               res.exc[`EXC_OVF] = !st1[79];
               res.exc[`EXC_UNF] = st1[79];
            end
         end
         OP_DIV: begin
            if (depth < 4'h2) begin
               res.exc[`EXC_INV] = 1'b1;
            end else if (st0 == 80'h0) begin
               res.exc[`EXC_ZDIV] = 1'b1;
            end else begin
               res.stk   = STK_POPWR;
               res.data  = st1 / st0;
               res.wrRes = 1'b1;
               res.exc[`EXC_PREC] = (st1 % st0) != 80'h0;
            end
         end
         OP_STORE: begin
            res.wrRes = 1'b1;
            res.data  = st0;
            if (depth == 4'h0) begin
               res.exc[`EXC_INV] = 1'b1;
            end
            case (fmt)
               FMT_I16: begin
                  res.data = {{64{st0[15]}}, st0[15:0]};
                  res.exc[`EXC_PREC] = lostBits(st0, 7'd16);
               end
               FMT_I32: begin
                  res.data = {{48{st0[31]}}, st0[31:0]};
                  res.exc[`EXC_PREC] = lostBits(st0, 7'd32);
               end
               FMT_I64: begin
                  res.data = {{16{st0[63]}}, st0[63:0]};
                  res.exc[`EXC_PREC] = lostBits(st0, 7'd64);
               end
               default: begin
                  res.data = st0;
               end
            endcase
         end
         OP_ENTER_PROTECTED_MODE_INSTR: begin
            res.enter_protected_mode_instr = 1'b1;
         end
         OP_CLEX: begin
            res.clex = 1'b1;
         end
         default: begin
            res.exc[`EXC_INV] = 1'b1;
         end
      endcase
      // an unknown format is an invalid operation; stack and result hold, but flag clear and protected-mode entry still act
      if (fmt == FMT_BAD) begin
         res.exc[`EXC_INV] = 1'b1;
      end
      if (res.exc[`EXC_INV]) begin
         res.stk   = STK_HOLD;
         res.wrRes = 1'b0;
      end
   end

endmodule : op_eval

// ===== hdl/math_coprocessor_port_glue.sv
// coprocessor port glue with its numeric execution core
//
// Summary of operation
// - coprocessor answers as an i/o device at ports COPROCESSOR_PORT_A, COPROCESSOR_PORT_B, COPROCESSOR_PORT_C.
// - busy is shown while executing; host wait stalls until released.
// - six exceptions: invalid, denormal, zero divide, overflow, ...
// - unmasked exception asserts error; masked exception does not.
// - error raises interrupt 13 and latches busy toward host.
// - byte write of zero to BUSY_LATCH_CLEAR clears busy latch and interrupt.
// - real mode after power-on reset, system reset or write to COPROCESSOR_MODE_RESET.
// - set-protected-mode instruction switches coprocessor to protected.
// - zero byte write to COPROCESSOR_MODE_RESET resets coprocessor back to real mode.
// - coprocessor runs from the host's clock, in synchronous mode.
// - eight 80-bit registers as stack or fixed set; top two operated.
// - seven formats: integers 16/32/64, packed decimal 80, reals.
`timescale 1ns/100ps
`include "copro_regs.svh"
module math_coprocessor_port_glue
   import copro_pkg::*;
(
   // clock, reset and freeze
   input  wire logic    mclk,
   input  wire logic    rst_b,
   input  wire logic    clkEn,
   // host i/o cycle
   input  wire io_req_s ioReq,
   output logic [15:0]  ioRdData,
   // status toward the host
   output logic         hostBusy,
   output logic         irq13,
   output logic         protMode
);

   // reset image of the glue state: masks all set, real mode, idle
   localparam glue_s GLUE_RST = '{
      rdData:    16'h0000,
      hostBusy:  1'b0,
      busyLatch: 1'b0,
      irq:       1'b0,
      errPrev:   1'b0,
      protMode:  1'b0,
      flags:     6'h00,
      mask:      `MASK_RST,
      operand:   80'h0,
      result:    80'h0,
      resIdx:    3'h0,
      opWord:    16'h0000,
      cnt:       8'h00,
      exec:      EX_IDLE
   };

   glue_s       r;
   glue_s       n;
   eval_s       ev;
   stk_e        stkCmd;
   logic [79:0] st0;
   logic [79:0] st1;
   logic [79:0] fixVal;
   logic [3:0]  depth;
   logic        errNow;
   logic        hitClr;
   logic        hitRst;
   logic        hitA;
   logic        hitB;
   logic        hitC;
   logic        done;
   logic        errNext;

   // address match on a full 16-bit i/o port
   function automatic logic portHit(input logic [15:0] addr,
                                    input logic [15:0] ofs);
      portHit = (addr == ofs);
   endfunction : portHit

   // one 16-bit word of the result, low word first
   function automatic logic [15:0] resWord(input logic [79:0] v,
                                           input logic [2:0] idx);
      case (idx)
         3'h0:    resWord = v[15:0];
         3'h1:    resWord = v[31:16];
         3'h2:    resWord = v[47:32];
         3'h3:    resWord = v[63:48];
         3'h4:    resWord = v[79:64];
         default: resWord = 16'h0000;
      endcase
   endfunction : resWord

   // register stack
   stack_file u_stack (
      .mclk   (mclk),
      .rst_b  (rst_b),
      .clkEn  (clkEn),
      .clear  (hitRst),
      .cmd    (stkCmd),
      .wrData (ev.data),
      .fixIdx (r.opWord[`IDX_MSB:`IDX_LSB]),
      .st0    (st0),
      .st1    (st1),
      .fixVal (fixVal),
      .depth  (depth)
   );

   // instruction execution and exception detection
   op_eval u_eval (
      .opWord  (r.opWord),
      .operand (r.operand),
      .st0     (st0),
      .st1     (st1),
      .fixVal  (fixVal),
      .depth   (depth),
      .res     (ev)
   );

   // port decode
   always_comb begin
      hitA   = portHit(ioReq.addr, `PORT_A_OFS);
      hitB   = portHit(ioReq.addr, `PORT_B_OFS);
      hitC   = portHit(ioReq.addr, `PORT_C_OFS);
      hitClr = ioReq.wr && ioReq.byteXfer
               && portHit(ioReq.addr, `BUSY_CLR_OFS)
               && ioReq.wrData[7:0] == `CLR_DATA;
      hitRst = ioReq.wr && portHit(ioReq.addr, `MODE_RST_OFS);
   end

   // error line: any flagged exception whose mask bit is clear
   assign errNow = |(r.flags & ~r.mask);

   // last cycle of an instruction
   assign done = (r.exec == EX_RUN) && (r.cnt == 8'h00);

   // stack pushes and pops only when an instruction completes without a mode-reset write
   assign stkCmd = (done && !hitRst) ? ev.stk : STK_HOLD;

   // next-state logic of the glue and sequencer
   always_comb begin
      n = r;

      // clear write drops the busy latch and the interrupt
      if (hitClr) begin
         n.busyLatch = 1'b0;
         n.irq       = 1'b0;
      end

      // instruction execution
      if (r.exec == EX_RUN) begin
         if (done) begin
            n.exec  = EX_IDLE;
            n.flags = r.flags | ev.exc;
            if (ev.clex) begin
               n.flags = 6'h00;
            end
            if (ev.wrRes) begin
               n.result = ev.data;
               n.resIdx = 3'h0;
            end
            if (ev.enter_protected_mode_instr) begin
               n.protMode = 1'b1;
            end
         end else begin
            n.cnt = r.cnt - 8'h01;
         end
      end

      // host writes to the data ports
      if (ioReq.wr && !ioReq.byteXfer) begin
         if (hitA && r.exec == EX_IDLE) begin
            n.opWord = ioReq.wrData;
            n.exec   = EX_RUN;
            n.cnt    = `EXEC_CYCLES - 8'h01;
         end
         if (hitB) begin
            n.operand = {ioReq.wrData, r.operand[79:16]};
         end
         if (hitC) begin
            n.mask = ioReq.wrData[5:0];
         end
      end

      // host reads: status, last opcode, result words
      if (ioReq.rd) begin
         if (hitA) begin
            n.rdData = {3'b000, depth, r.protMode,
                        (r.exec == EX_RUN), errNow, r.flags};
         end else if (hitB) begin
            n.rdData = r.opWord;
         end else if (hitC) begin
            n.rdData = resWord(r.result, r.resIdx);
            if (r.resIdx == `RES_WORDS - 3'h1) begin
               n.resIdx = 3'h0;
            end else begin
               n.resIdx = r.resIdx + 3'h1;
            end
         end else begin
            n.rdData = 16'h0000;
         end
      end

      // any write to the mode-reset port resets the core to real mode
      if (hitRst) begin
         n.flags    = 6'h00;
         n.mask     = `MASK_RST;
         n.protMode = 1'b0;
         n.exec     = EX_IDLE;
         n.cnt      = 8'h00;
         n.operand  = 80'h0;
         n.result   = 80'h0;
         n.resIdx   = 3'h0;
         n.opWord   = 16'h0000;
      end

      // error edge latches at the flag edge, so busy never dips; set wins
      errNext   = |(n.flags & ~n.mask);
      n.errPrev = errNext;
      if (errNext && !r.errPrev) begin
         n.busyLatch = 1'b1;
         n.irq       = 1'b1;
      end

      // host sees live busy or the error latch
      n.hostBusy = (n.exec == EX_RUN) || n.busyLatch;
   end

   // single clock shared with the host; reset gives real mode
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         r <= GLUE_RST;
      end else if (clkEn) begin
         r <= n;
      end
   end

   // outputs straight from the state register
   assign ioRdData = r.rdData;
   assign hostBusy = r.hostBusy;
   assign irq13    = r.irq;
   assign protMode = r.protMode;

endmodule : math_coprocessor_port_glue

// ===== test/copro_glue_properties.sv
// concurrent checks on the coprocessor port glue
`timescale 1ns/100ps
`include "copro_regs.svh"
module copro_glue_checker
   import copro_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        clkEn,
   // host i/o cycle and answers
   input  wire io_req_s     ioReq,
   input  wire logic [15:0] ioRdData,
   input  wire logic        hostBusy,
   input  wire logic        irq13,
   input  wire logic        protMode
);
   // decoded host cycles
   wire logic f1Wr = clkEn && ioReq.wr && ioReq.addr == `MODE_RST_OFS;
   wire logic clrWr = clkEn && ioReq.wr && ioReq.byteXfer
      && ioReq.addr == `BUSY_CLR_OFS && ioReq.wrData[7:0] == `CLR_DATA;
   wire logic anyRd = clkEn && ioReq.rd;
   wire logic mapRd = ioReq.addr == `PORT_A_OFS
      || ioReq.addr == `PORT_B_OFS || ioReq.addr == `PORT_C_OFS;

   // execution cycles left, kept from the port contract
   logic [3:0] runLeft;
   wire logic  opTaken = clkEn && ioReq.wr && !ioReq.byteXfer
      && ioReq.addr == `PORT_A_OFS && runLeft == 4'h0;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         runLeft <= 4'h0;
      end else if (f1Wr) begin
         runLeft <= 4'h0;
      end else if (opTaken) begin
         runLeft <= 4'h8;
      end else if (clkEn && runLeft != 4'h0) begin
         runLeft <= runLeft - 4'h1;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   // opcode taken by an idle core
   sequence opStart;
      clkEn && ioReq.wr && !ioReq.byteXfer && !hostBusy
         && ioReq.addr == `PORT_A_OFS;
   endsequence
   // eight execution cycles with no mode reset
   sequence execRun;
      (!f1Wr) [*8];
   endsequence

   busy_rise_a: assert property (opStart |=> hostBusy)
      else $error("busy did not rise after an opcode");
   exec_done_a: assert property (
      opStart ##1 execRun |=> !hostBusy || irq13)
      else $error("busy not released after execution");
   irq_busy_a: assert property (irq13 |-> hostBusy)
      else $error("interrupt pending without busy");
   irq_hold_a: assert property (irq13 && !clrWr |=> irq13)
      else $error("interrupt dropped without a clear");
   irq_clear_a: assert property (
      clrWr && irq13 && runLeft == 4'h0 |=> !irq13 && !hostBusy)
      else $error("clear write left interrupt or busy");
   mode_reset_a: assert property (f1Wr |=> !protMode)
      else $error("mode reset left protected mode");
   pm_cause_a: assert property ($rose(protMode) |-> $past(hostBusy))
      else $error("protected mode without an instruction");
   unmapped_rd_a: assert property (
      anyRd && !mapRd |=> ioRdData == 16'h0000)
      else $error("unmapped read returned data");
   rd_hold_a: assert property (!anyRd |=> $stable(ioRdData))
      else $error("read data changed without a read");
   status_a: assert property (
      anyRd && ioReq.addr == `PORT_A_OFS && !hostBusy
      |=> ioRdData[8] == protMode && ioRdData[15:13] == 3'h0)
      else $error("status word mode bit wrong");
endmodule : copro_glue_checker

bind math_coprocessor_port_glue copro_glue_checker copro_glue_checker_inst (
   .mclk(mclk), .rst_b(rst_b), .clkEn(clkEn), .ioReq(ioReq),
   .ioRdData(ioRdData), .hostBusy(hostBusy), .irq13(irq13),
   .protMode(protMode));

// ===== test/host_model.sv
// host side model: i/o cycles toward the glue and the busy wait
`timescale 1ns/100ps
module host_model
   import copro_pkg::*;
(
   // clock
   input  wire logic        mclk,
   // answers from the glue
   input  wire logic        hostBusy,
   input  wire logic [15:0] ioRdData,
   // i/o cycle toward the glue
   output io_req_s          ioReq
);
   // bus idle at time zero
   initial ioReq = '0;

   // one strobe cycle, raised and ended at falling edges
   task automatic cycle(input logic [15:0] a, input logic [15:0] d,
                        input logic w, input logic b);
      @(negedge mclk);
      ioReq = '{addr: a, wrData: d, wr: w, rd: !w, byteXfer: b};
      @(negedge mclk);
      ioReq.wr = 1'b0;
      ioReq.rd = 1'b0;
      // released lines show the inverse, never the last value
      ioReq.addr = ~a;
      ioReq.wrData = ~d;
   endtask : cycle

   // opcodes and operands go out as writes
   task automatic wr(input logic [15:0] a, input logic [15:0] d,
                     input logic b);
      cycle(a, d, 1'b1, b);
   endtask : wr

   // results come back as reads, data one cycle after the strobe
   task automatic rd(input logic [15:0] a, output logic [15:0] q);
      cycle(a, 16'h0000, 1'b0, 1'b0);
      q = ioRdData;
   endtask : rd

   // wait instruction: stall while busy, bounded at 20 cycles
   task automatic wait_idle(output int n);
      n = 0;
      while (hostBusy === 1'b1 && n < 20) begin
         n++;
         @(negedge mclk);
      end
   endtask : wait_idle
endmodule : host_model

// ===== test/tb.sv
// testbench: port decode, execution, error latch and mode flow
`timescale 1ns/100ps
`include "copro_regs.svh"
module tb
   import copro_pkg::*;
;
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] exp;
   } row_s;

   logic        mclk;
   logic        rst_b;
   logic        clkEn;
   io_req_s     ioReq;
   logic [15:0] ioRdData;
   logic        hostBusy;
   logic        irq13;
   logic        protMode;
   logic [15:0] q;
   int          n;
   int          miscompares;
   int          samplesChecked;
   row_s        rows [7];

   // device under test and the host beside it
   math_coprocessor_port_glue math_coprocessor_port_glue_inst (
      .mclk(mclk), .rst_b(rst_b), .clkEn(clkEn), .ioReq(ioReq),
      .ioRdData(ioRdData), .hostBusy(hostBusy), .irq13(irq13),
      .protMode(protMode));
   host_model host_model_inst (
      .mclk(mclk), .hostBusy(hostBusy), .ioRdData(ioRdData),
      .ioReq(ioReq));

   // 10 MHz clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // compare helpers
   task automatic chk16(input string nm, input logic [15:0] e, g);
      samplesChecked++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk16

   task automatic chkBit(input string nm, input logic e, g);
      samplesChecked++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask : chkBit

   // opcode write, then host wait with busy cycles counted
   task automatic op(input logic [15:0] w, input logic [15:0] cyc);
      host_model_inst.wr(`PORT_A_OFS, w, 1'b0);
      host_model_inst.wait_idle(n);
      chk16("busy cycles", cyc, 16'(n));
      // a spent wait bound is already a mismatch; stop here
      if (n >= 20) begin
         close_out();
      end
   endtask : op

   // five operand words, low word first, then a load opcode
   task automatic ld(input logic [15:0] w, input logic [15:0] opc);
      host_model_inst.wr(`PORT_B_OFS, w, 1'b0);
      repeat (4) host_model_inst.wr(`PORT_B_OFS, 16'h0000, 1'b0);
      op(opc, 16'h0008);
   endtask : ld

   // verdict and end of run
   task automatic close_out();
      $display("checked %0d mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out

   // main sequence
   initial begin
      rst_b = 1'b0;
      clkEn = 1'b1;
      miscompares = 0;
      samplesChecked = 0;
      rows = '{'{16'h00F8, 16'h0000}, '{16'h00FA, 16'h0000},
               '{16'h00FC, 16'h0000}, '{16'h00F0, 16'h0000},
               '{16'h00F1, 16'h0000}, '{16'h00FE, 16'h0000},
               '{16'h0000, 16'h0000}};
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      rst_b = 1'b1;
      // stray writes outside the map change nothing
      host_model_inst.wr(16'h00FE, 16'hFFFF, 1'b0);
      host_model_inst.wr(16'h00F9, 16'hFFFF, 1'b1);
      foreach (rows[i]) begin
         host_model_inst.rd(rows[i].addr, q);
         chk16("port read", rows[i].exp, q);
      end
      // operand low word first, real load, masked faults
      ld(16'h0001, 16'h0061);
      op(16'h000F, 16'h0008);
      chkBit("masked irq", 1'b0, irq13);
      host_model_inst.rd(`PORT_A_OFS, q);
      chk16("status", 16'h0203, q);
      // clear flags, unmask, then an unmasked fault latches
      op(16'h0009, 16'h0008);
      host_model_inst.wr(`PORT_C_OFS, 16'h0000, 1'b0);
      host_model_inst.wr(`PORT_A_OFS, 16'h000F, 1'b0);
      n = 0;
      repeat (12) begin
         @(negedge mclk);
         n += (hostBusy === 1'b1);
      end
      chk16("busy held cycles", 16'h000C, 16'(n));
      chkBit("irq raised", 1'b1, irq13);
      host_model_inst.wr(`BUSY_CLR_OFS, 16'h0001, 1'b1);
      host_model_inst.wr(`BUSY_CLR_OFS, 16'h0000, 1'b0);
      chkBit("irq kept", 1'b1, irq13);
      host_model_inst.wr(`BUSY_CLR_OFS, 16'h0000, 1'b1);
      chkBit("irq cleared", 1'b0, irq13);
      chkBit("busy cleared", 1'b0, hostBusy);
      // opcode written during execution is dropped
      host_model_inst.wr(`PORT_A_OFS, 16'h0000, 1'b0);
      op(16'h0007, 16'h0006);
      chkBit("dropped opcode", 1'b0, protMode);
      host_model_inst.rd(`PORT_B_OFS, q);
      chk16("last opcode", 16'h0000, q);
      // protected mode and the return through the mode port
      op(16'h0007, 16'h0008);
      chkBit("protected", 1'b1, protMode);
      host_model_inst.wr(`MODE_RST_OFS, 16'h0000, 1'b1);
      chkBit("real mode", 1'b0, protMode);
      host_model_inst.rd(`PORT_A_OFS, q);
      chk16("status after mode reset", 16'h0000, q);
      // top-two arithmetic, divide and a fixed-index push
      ld(16'h0005, 16'h0001);
      ld(16'h0003, 16'h0001);
      op(16'h0003, 16'h0008);
      ld(16'h0002, 16'h0001);
      op(16'h0005, 16'h0008);
      host_model_inst.rd(`PORT_C_OFS, q);
      chk16("quotient", 16'h0004, q);
      op(16'h0108, 16'h0008);
      op(16'h0004, 16'h0008);
      host_model_inst.rd(`PORT_C_OFS, q);
      chk16("difference", 16'h0002, q);
      // system reset in mid-run, while an instruction executes
      host_model_inst.wr(`PORT_A_OFS, 16'h0007, 1'b0);
      host_model_inst.rd(`PORT_B_OFS, q);
      chk16("last opcode", 16'h0007, q);
      rst_b = 1'b0;
      @(negedge mclk);
      chkBit("reset mode", 1'b0, protMode);
      chkBit("reset busy", 1'b0, hostBusy);
      chk16("reset read data", 16'h0000, ioRdData);
      rst_b = 1'b1;
      repeat (10) @(negedge mclk);
      chkBit("aborted instruction", 1'b0, protMode);
      host_model_inst.rd(`PORT_A_OFS, q);
      chk16("status after reset", 16'h0000, q);
      close_out();
   end
endmodule : tb
